// ---- core_ops.sv ----
// Purpose: Executes branch, bit, shift, flag and load instructions of a small core
// Assumes: Avalon-MM slave for software; data-space read data valid while mem_read is high
// Notes: Writing the instruction register starts one instruction
// Operation
// [RULE_01] Branch when interrupts on: PC+k+1
// [RULE_02] Branch when interrupts off: PC+k+1
// [RULE_03] I/O bit set, two cycles
// [RULE_04] I/O bit clear, two cycles
// [RULE_05] Logical and arithmetic shifts update flags
// [RULE_06] Rotates through carry update flags
// [RULE_07] Single flag set or clear only
// [RULE_08] Register bit copied into transfer flag
// [RULE_09] Transfer flag copied into register bit
// [RULE_10] Post-increment load, pointer plus one
// [RULE_11] Pre-decrement load, pointer minus one first
// [RULE_12] Displaced load leaves pointer unchanged
// [RULE_13] Direct load from constant address
// [RULE_14] Branch: one cycle untaken, two taken
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`include "core_ops_params.svh"
`default_nettype none
module core_ops (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] mem_addr,
  output logic mem_read,
  output logic mem_write,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  // Architectural state
  logic [7:0] gpr [0:31]; // Working registers
  logic [7:0] status_flags_register; // Flag byte
  logic [15:0] pc; // Program counter
  logic [4:0] gpr_sel; // Register shown on readback
  logic [31:0] instr; // Latched instruction
  core_ops_pkg::exec_state_t state; // Sequencer
  logic [1:0] cycles; // Cycles spent by last instruction
  logic busy_done; // Instruction complete pulse

  // Instruction fields
  logic [5:0] op;
  logic [4:0] rd;
  logic [4:0] rr;
  logic [2:0] bsel;
  logic [15:0] imm;
  assign op = instr[`OP_MSB:`OP_LSB];
  assign rd = instr[`RD_LSB+4:`RD_LSB];
  assign rr = instr[`RR_LSB+4:`RR_LSB];
  assign bsel = instr[`BIT_LSB+2:`BIT_LSB];
  assign imm = instr[15:0];

  // Pointer base for the loads; rr[1:0] picks X, Y or Z
  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    case (sel)
      2'h0: ptr_lo = `PTR_X_LO;
      2'h1: ptr_lo = `PTR_Y_LO;
      default: ptr_lo = `PTR_Z_LO;
    endcase
  endfunction : ptr_lo

  logic [4:0] plo;
  logic [15:0] ptr;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  assign plo = ptr_lo(rr[1:0]);
  assign ptr = {gpr[plo + 5'h01], gpr[plo]};
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_inc = ptr + 16'h0001;

  // Shift results
  logic [7:0] sh_out;
  logic [7:0] sh_flags;
  shift_unit u_shift (
    .op(op),
    .din(gpr[rd]),
    .carry_in(status_flags_register[`FLAG_C]),
    .dout(sh_out),
    .flags_out(sh_flags),
    .flags_in(status_flags_register)
  );

  logic is_start;
  logic is_branch;
  logic br_taken;
  assign is_start = avs_write && (avs_address == `REG_INSTR) && (state == core_ops_pkg::ST_IDLE);
  assign is_branch = (op == 6'h01) || (op == 6'h02);
  // Condition on the global interrupt flag
  assign br_taken = (op == 6'h01) ? status_flags_register[`FLAG_I] // see [RULE_01]
                                  : !status_flags_register[`FLAG_I]; // see [RULE_02]

  // Loads of every addressing form; shared by the memory port and the checks
  function automatic logic is_load_op(input logic [5:0] o);
    is_load_op = (o >= 6'h0E) && (o <= 6'h12);
  endfunction : is_load_op

  // Instructions needing a second cycle
  function automatic logic two_cycle(input logic [5:0] o, input logic taken);
    two_cycle = (o == 6'h03) || (o == 6'h04) || (o >= 6'h0E && o <= 6'h12)
             || (((o == 6'h01) || (o == 6'h02)) && taken);
  endfunction : two_cycle

  // Memory address for the current instruction
  always_comb begin
    case (op)
      6'h03, 6'h04: mem_addr = {11'h000, imm[4:0]} + 16'h0020; // I/O space
      6'h10: mem_addr = ptr_dec; // see [RULE_11]
      6'h11: mem_addr = ptr + {10'h000, imm[5:0]}; // see [RULE_12]
      6'h12: mem_addr = imm; // see [RULE_13]
      default: mem_addr = ptr; // see [RULE_10]
    endcase
  end

  // Read in the first cycle, write back in the second for I/O bit ops; loads read in the first cycle only;
  // other ops keep the port quiet so that no I/O location ever sees a stray read
  assign mem_read = (state == core_ops_pkg::ST_SECOND)
                 && (is_load_op(op) || (op == 6'h03) || (op == 6'h04));
  assign mem_write = 1'b0 || ((state == core_ops_pkg::ST_DONE) && (op == 6'h03 || op == 6'h04));

  // I/O bit write data registered from the read value
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_wdata <= 8'h00;
    end else if (state == core_ops_pkg::ST_SECOND) begin
      mem_wdata <= mem_rdata;
      mem_wdata[bsel] <= (op == 6'h03); // see [RULE_03] see [RULE_04]
    end
  end

  // Sequencer; ST_DONE is the second cycle for two-cycle work
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= core_ops_pkg::ST_IDLE;
      cycles <= 2'h0;
      busy_done <= 1'b0;
    end else begin
      busy_done <= 1'b0;
      case (state)
        core_ops_pkg::ST_IDLE: begin
          if (is_start) begin
            state <= core_ops_pkg::ST_SECOND;
          end
        end
        core_ops_pkg::ST_SECOND: begin
          if (two_cycle(op, br_taken)) begin // see [RULE_14]
            state <= core_ops_pkg::ST_DONE;
          end else begin
            state <= core_ops_pkg::ST_IDLE;
            cycles <= 2'h1;
            busy_done <= 1'b1;
          end
        end
        core_ops_pkg::ST_DONE: begin
          state <= core_ops_pkg::ST_IDLE;
          cycles <= `CYC_MEM;
          busy_done <= 1'b1;
        end
        default: state <= core_ops_pkg::ST_IDLE;
      endcase
    end
  end

  // Instruction latch and readback select
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      instr <= 32'h0000_0000;
      gpr_sel <= 5'h00;
    end else begin
      if (is_start) begin
        instr <= avs_writedata;
      end
      if (avs_write && avs_address == `REG_GPR_SEL) begin
        gpr_sel <= avs_writedata[4:0];
      end
    end
  end

  // Program counter: one step per instruction, taken branch adds k+1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc <= `PC_RESET;
    end else if (avs_write && avs_address == `REG_PC && state == core_ops_pkg::ST_IDLE) begin
      pc <= avs_writedata[15:0];
    end else if (state == core_ops_pkg::ST_SECOND) begin
      if (is_branch && br_taken) begin
        pc <= pc + {{9{imm[6]}}, imm[6:0]} + 16'h0001; // see [RULE_01] see [RULE_02]
      end else begin
        pc <= pc + 16'h0001;
      end
    end
  end

  // Flag byte; only the instruction's own flags change
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_flags_register <= `STATUS_RESET;
    end else if (avs_write && avs_address == `REG_STATUS && state == core_ops_pkg::ST_IDLE) begin
      status_flags_register <= avs_writedata[7:0];
    end else if (state == core_ops_pkg::ST_SECOND) begin
      case (op)
        6'h05, 6'h06, 6'h07, 6'h08, 6'h09: begin
          status_flags_register <= sh_flags; // see [RULE_05] see [RULE_06]
        end
        6'h0A: status_flags_register[bsel] <= 1'b1; // see [RULE_07]
        6'h0B: status_flags_register[bsel] <= 1'b0; // see [RULE_07]
        6'h0C: status_flags_register[`FLAG_T] <= gpr[rr][bsel]; // see [RULE_08]
        default: begin
          // Loads, branches and I/O ops leave flags alone
        end
      endcase
    end
  end

  // Working registers: results, loaded bytes and pointer updates
  // Loaded bytes are taken while mem_read is high; the data space drives nothing valid later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= 8'h00;
      end
    end else if (state == core_ops_pkg::ST_SECOND) begin
      case (op)
        6'h05, 6'h06, 6'h07, 6'h08, 6'h09: gpr[rd] <= sh_out;
        6'h0D: gpr[rd][bsel] <= status_flags_register[`FLAG_T]; // see [RULE_09]
        6'h0F: begin // Byte read from the old pointer, pointer steps on
          {gpr[plo + 5'h01], gpr[plo]} <= ptr_inc; // see [RULE_10]
          gpr[rd] <= mem_rdata; // see [RULE_10]
        end
        6'h10: begin // Pointer steps back, byte read from the new value
          {gpr[plo + 5'h01], gpr[plo]} <= ptr_dec; // see [RULE_11]
          gpr[rd] <= mem_rdata; // see [RULE_11]
        end
        6'h0E, 6'h11, 6'h12: begin // Pointer left as it is
          gpr[rd] <= mem_rdata; // see [RULE_12] see [RULE_13]
        end
        default: begin
        end
      endcase
    end
  end

  // Avalon reads answer at once; instruction write waits until idle
  assign avs_waitrequest = avs_write && (state != core_ops_pkg::ST_IDLE);

  // Read mux; unmapped reads return zero
  always_comb begin
    case (avs_address)
      `REG_INSTR: avs_readdata = instr;
      `REG_STATUS: avs_readdata = {22'h00_0000, cycles, status_flags_register};
      `REG_PC: avs_readdata = {15'h0000, state != core_ops_pkg::ST_IDLE, pc};
      `REG_GPR_SEL: avs_readdata = {19'h0_0000, gpr_sel, gpr[gpr_sel]};
      default: avs_readdata = 32'h0000_0000;
    endcase
  end

  // Checks: branches and sequencing
  a_branch_taken_pc: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_01]
    (state == core_ops_pkg::ST_SECOND && is_branch && br_taken)
    |=> pc == $past(pc) + {{9{$past(imm[6])}}, $past(imm[6:0])} + 16'h0001)
    else $error("taken branch pc wrong");
  a_branch_cycles: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_14]
    (state == core_ops_pkg::ST_SECOND && is_branch && !br_taken)
    |=> state == core_ops_pkg::ST_IDLE && cycles == 2'h1)
    else $error("untaken branch not one cycle");
  a_done_pulse: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_14]
    busy_done |-> state == core_ops_pkg::ST_IDLE && cycles != 2'h0)
    else $error("completion without cycle count");
  a_read_no_wait: assert property (@(posedge ref_clk) disable iff (rst)
    avs_read |-> !avs_waitrequest)
    else $error("register read stalled");
  // Checks: I/O bit operations
  a_io_two_cycle: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_03]
    (state == core_ops_pkg::ST_SECOND && (op == 6'h03 || op == 6'h04))
    |=> mem_write ##1 state == core_ops_pkg::ST_IDLE)
    else $error("io bit op not two cycles");
  a_io_bit_value: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_04]
    mem_write |-> mem_wdata[bsel] == (op == 6'h03))
    else $error("io bit value wrong");
  // Checks: flags and transfer bit
  a_flag_only_one: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_07]
    (state == core_ops_pkg::ST_SECOND && op == 6'h0A)
    |=> status_flags_register == ($past(status_flags_register) | (8'h01 << $past(bsel))))
    else $error("flag set touched others");
  a_flag_clear_one: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_07]
    (state == core_ops_pkg::ST_SECOND && op == 6'h0B)
    |=> status_flags_register == ($past(status_flags_register) & ~(8'h01 << $past(bsel))))
    else $error("flag clear touched others");
  a_bst_copy: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_08]
    (state == core_ops_pkg::ST_SECOND && op == 6'h0C)
    |=> status_flags_register[`FLAG_T] == $past(gpr[rr][bsel]))
    else $error("bit store wrong");
  a_bld_copy: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_09]
    (state == core_ops_pkg::ST_SECOND && op == 6'h0D)
    |=> gpr[$past(rd)][$past(bsel)] == $past(status_flags_register[`FLAG_T]))
    else $error("bit load wrong");
  // Checks: shifts and rotates
  a_shift_zero: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_05]
    (state == core_ops_pkg::ST_SECOND && op == 6'h05)
    |=> status_flags_register[`FLAG_Z] == (gpr[$past(rd)] == 8'h00))
    else $error("shift zero flag wrong");
  a_ror_carry: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_06]
    (state == core_ops_pkg::ST_SECOND && op == 6'h08)
    |=> status_flags_register[`FLAG_C] == $past(gpr[rd][0])
        && gpr[$past(rd)][7] == $past(status_flags_register[`FLAG_C]))
    else $error("rotate right carry wrong");
  // Checks: loads; a pointer that is also the destination is left out
  a_load_noflags: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_10]
    (state == core_ops_pkg::ST_SECOND && is_load_op(op))
    |=> $stable(status_flags_register) ##1 $stable(status_flags_register))
    else $error("load changed flags");
  a_postinc_ptr: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_10]
    (state == core_ops_pkg::ST_SECOND && op == 6'h0F && rd[4:1] != plo[4:1])
    |=> ptr == $past(ptr) + 16'h0001)
    else $error("post-increment pointer wrong");
  a_predec_addr: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_11]
    (state == core_ops_pkg::ST_SECOND && op == 6'h10) |-> mem_addr == ptr - 16'h0001)
    else $error("predec address wrong");
  a_disp_ptr_kept: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_12]
    (state == core_ops_pkg::ST_SECOND && op == 6'h11 && rd[4:1] != plo[4:1])
    |=> $stable(ptr))
    else $error("displaced load moved pointer");
  a_direct_addr: assert property (@(posedge ref_clk) disable iff (rst) // see [RULE_13]
    (state == core_ops_pkg::ST_SECOND && op == 6'h12) |-> mem_read && mem_addr == imm)
    else $error("direct load address wrong");
  // Scenarios worth seeing
  c_branch_taken: cover property (@(posedge ref_clk)
    state == core_ops_pkg::ST_SECOND && is_branch && br_taken);
  c_io_set: cover property (@(posedge ref_clk)
    mem_write && op == 6'h03);
  c_load_inc: cover property (@(posedge ref_clk)
    state == core_ops_pkg::ST_DONE && op == 6'h0F);
  c_load_dec: cover property (@(posedge ref_clk)
    state == core_ops_pkg::ST_DONE && op == 6'h10);
  c_rotate: cover property (@(posedge ref_clk)
    state == core_ops_pkg::ST_SECOND && op == 6'h08);
endmodule : core_ops
`default_nettype wire

// ---- core_ops_params.svh ----
// Purpose: Offsets, field positions, reset values and counts for the core ops block
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef CORE_OPS_PARAMS_SVH
`define CORE_OPS_PARAMS_SVH

// Register offsets (byte addresses, one aligned word each)
`define REG_INSTR 4'h0
`define REG_STATUS 4'h4
`define REG_PC 4'h8
`define REG_GPR_SEL 4'hC

// Instruction word field positions
`define OP_MSB 31
`define OP_LSB 26
`define RD_LSB 21
`define RR_LSB 16
`define BIT_LSB 13
`define IMM_LSB 0

// Status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// Pointer register pairs
`define PTR_X_LO 5'h1A
`define PTR_Y_LO 5'h1C
`define PTR_Z_LO 5'h1E

// Reset values
`define STATUS_RESET 8'h00
`define PC_RESET 16'h0000

// Cycle counts
`define CYC_BRANCH_TAKEN 2'h2
`define CYC_MEM 2'h2

`endif

// ---- core_ops_pkg.sv ----
// Purpose: Types shared by the core ops block
// Assumes: core_ops_params.svh holds the numbers
// Notes: Opcodes and states only
`default_nettype none
package core_ops_pkg;
  // Instruction opcodes in the control word
  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_BR_ION = 6'h01,
    OP_BR_IOFF = 6'h02,
    OP_IO_SET = 6'h03,
    OP_IO_CLR = 6'h04,
    OP_LSL = 6'h05,
    OP_LSR = 6'h06,
    OP_ROL = 6'h07,
    OP_ROR = 6'h08,
    OP_ASR = 6'h09,
    OP_FSET = 6'h0A,
    OP_FCLR = 6'h0B,
    OP_BST = 6'h0C,
    OP_BLD = 6'h0D,
    OP_LD_PLAIN = 6'h0E,
    OP_LD_INC = 6'h0F,
    OP_LD_DEC = 6'h10,
    OP_LD_DISP = 6'h11,
    OP_LD_DIRECT = 6'h12
  } opcode_t;

  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SECOND,
    ST_DONE
  } exec_state_t;
endpackage : core_ops_pkg
`default_nettype wire

// ---- shift_unit.sv ----
// Purpose: Shift and rotate datapath with flag results
// Assumes: Combinational, used by the core ops top
// Notes: V is N xor C; S is N xor V
`include "core_ops_params.svh"
`default_nettype none
module shift_unit (
  input wire logic [5:0] op,
  input wire logic [7:0] din,
  input wire logic carry_in,
  output logic [7:0] dout,
  output logic [7:0] flags_out,
  input wire logic [7:0] flags_in
);
  logic c_new; // Bit shifted out

  // Datapath for the five shift kinds
  always_comb begin
    dout = din;
    c_new = flags_in[`FLAG_C];
    case (op)
      6'h05: begin // Left, zero into bit 0
        dout = {din[6:0], 1'b0}; // see [RULE_05]
        c_new = din[7];
      end
      6'h06: begin // Right, zero into bit 7
        dout = {1'b0, din[7:1]}; // see [RULE_05]
        c_new = din[0];
      end
      6'h07: begin // Old carry into bit 0
        dout = {din[6:0], carry_in}; // see [RULE_06]
        c_new = din[7];
      end
      6'h08: begin // Old carry into bit 7
        dout = {carry_in, din[7:1]}; // see [RULE_06]
        c_new = din[0];
      end
      6'h09: begin // Sign bit kept
        dout = {din[7], din[7:1]}; // see [RULE_05]
        c_new = din[0];
      end
      default: begin
        dout = din;
      end
    endcase
  end

  // Z, C, N, V and S follow the result
  always_comb begin
    flags_out = flags_in;
    flags_out[`FLAG_C] = c_new;
    flags_out[`FLAG_Z] = (dout == 8'h00);
    flags_out[`FLAG_N] = dout[7];
    flags_out[`FLAG_V] = dout[7] ^ c_new;
    flags_out[`FLAG_S] = c_new;
  end
endmodule : shift_unit
`default_nettype wire

// ---- data_space_model.sv ----
// Purpose: Byte-wide data space seen by the core's memory port
// Assumes: Read data must be valid in the same cycle as mem_read
// Notes: A released data line shows the inverted last value
`default_nettype none
module data_space_model (
  input wire logic ref_clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535]; // Whole data space, I/O from 0x20 up
  logic [7:0] last_q = 8'h00; // Last value put on the line
  // Inverted value when idle, so stale data can never look right
  always_comb begin
    mem_rdata = mem_read ? mem[mem_addr] : ~last_q;
  end
  // Writes land on the clock edge, like a real synchronous array
  always @(posedge ref_clk) begin
    if (mem_read) begin
      last_q <= mem[mem_addr];
    end
    if (mem_write) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule : data_space_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench driving instructions over the register bus
// Assumes: Pointer select 0 picks X, 1 Y, 2 Z; 0xC write only selects
// Notes: Registers are filled through direct loads from the model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0; // 100 MHz
  logic rst = 1'b1; // Held for five cycles
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] mem_addr;
  logic mem_read;
  logic mem_write;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  int err_total = 0; // Mismatches
  int check_count = 0; // Comparisons
  int cyc = 0; // Cycle count for the hang guard
  logic [31:0] rv; // Scratch read value
  logic [8:0] sr; // Expected carry and result
  logic [7:0] ef; // Expected flags
  logic [7:0] dv [0:2] = '{8'h81, 8'h40, 8'h01}; // Shift operands

  always #5 ref_clk = ~ref_clk;

  core_ops dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_addr(mem_addr), .mem_read(mem_read), .mem_write(mem_write),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  data_space_model mem_u (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_read(mem_read),
    .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Guard against a stalled bus or a stuck busy flag
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Bus write: held until waitrequest is sampled low at a rising edge, released there
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  // Bus read: data taken at the same rising edge that sees waitrequest low
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] rd,
      input logic [4:0] rr, input logic [2:0] b, input logic [15:0] imm);
    mk = {op, rd, rr, imm | {b, 13'h0000}};
  endfunction : mk

  // Start one instruction and wait, bounded, until busy drops
  task automatic run(input logic [31:0] instr);
    int n;
    bus_wr(4'h0, instr);
    n = 0;
    do begin
      bus_rd(4'h8, rv);
      n++;
    end while (rv[16] !== 1'b0 && n < 20);
    chk("busy", {31'h0, rv[16]}, 32'h0);
  endtask : run

  task automatic rreg(input logic [4:0] n, output logic [31:0] v);
    bus_wr(4'hC, {27'h000_0000, n}); // Select field sits in the low bits
    bus_rd(4'hC, v);
    v = {24'h00_0000, v[7:0]};
  endtask : rreg

  task automatic direct_load(input logic [4:0] rd, input logic [15:0] a, input logic [7:0] v);
    mem_u.mem[a] = v;
    run(mk(core_ops_pkg::OP_LD_DIRECT, rd, 5'h00, 3'h0, a));
  endtask : direct_load

  // Indirect load case: value, pointer after, flags kept, two cycles
  task automatic ld_case(input logic [5:0] op, input logic [4:0] p, input logic [15:0] q,
      input logic [15:0] a, input logic [7:0] v, input logic [4:0] lo, input logic [15:0] ep);
    logic [31:0] h;
    mem_u.mem[a] = v;
    bus_wr(4'h4, 32'h0000_00A5);
    run(mk(op, 5'h03, p, 3'h0, q));
    rreg(5'h03, rv);
    chk("load value", rv, {24'h0, v});
    rreg(lo, rv);
    rreg(lo + 5'h01, h);
    chk("pointer", {h[7:0], rv[7:0]}, {16'h0, ep});
    bus_rd(4'h4, rv);
    chk("load flags", rv[9:0], 10'h2A5);
  endtask : ld_case

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    bus_rd(4'h4, rv);
    chk("status reset", rv[7:0], 8'h00);
    // Direct load leaves flags alone
    bus_wr(4'h4, 32'h0000_005A);
    direct_load(5'h10, 16'h0123, 8'hC3);
    rreg(5'h10, rv);
    chk("direct load", rv, 32'h0000_00C3);
    bus_rd(4'h4, rv);
    chk("direct flags", rv[7:0], 8'h5A);
    $display("test direct load done");
    // Shifts and rotates, each with and without carry in
    for (int op = 5; op <= 9; op++) begin
      for (int j = 0; j < 3; j++) begin
        direct_load(5'h10, 16'h0100, dv[j]);
        bus_wr(4'h4, {24'h0, 7'b1110000, j[0]});
        run(mk(op[5:0], 5'h10, 5'h00, 3'h0, 16'h0000));
        case (op)
          5: sr = {dv[j][7], dv[j][6:0], 1'b0};
          6: sr = {dv[j][0], 1'b0, dv[j][7:1]};
          7: sr = {dv[j][7], dv[j][6:0], j[0]};
          8: sr = {dv[j][0], j[0], dv[j][7:1]};
          default: sr = {dv[j][0], dv[j][7], dv[j][7:1]};
        endcase
        ef = {3'b111, 1'b0, sr[7] ^ sr[8], sr[7], sr[7:0] == 8'h00, sr[8]};
        ef[4] = ef[2] ^ ef[3];
        rreg(5'h10, rv);
        chk("shift result", rv, {24'h0, sr[7:0]});
        bus_rd(4'h4, rv);
        chk("shift flags", rv[9:0], {2'h1, ef});
      end
    end
    $display("test shifts done");
    // Every flag set from clear and cleared from set
    for (int s = 0; s < 8; s++) begin
      bus_wr(4'h4, 32'h0000_0000);
      run(mk(core_ops_pkg::OP_FSET, 5'h00, 5'h00, s[2:0], 16'h0000));
      bus_rd(4'h4, rv);
      chk("flag set", rv[9:0], {2'h1, 8'h01 << s});
      bus_wr(4'h4, 32'h0000_00FF);
      run(mk(core_ops_pkg::OP_FCLR, 5'h00, 5'h00, s[2:0], 16'h0000));
      bus_rd(4'h4, rv);
      chk("flag clear", rv[9:0], {2'h1, ~(8'h01 << s)});
    end
    $display("test flags done");
    // Register bit to transfer flag and back
    direct_load(5'h10, 16'h0101, 8'hA5);
    direct_load(5'h11, 16'h0102, 8'h00);
    bus_wr(4'h4, 32'h0000_0081);
    run(mk(core_ops_pkg::OP_BST, 5'h00, 5'h10, 3'h2, 16'h0000));
    bus_rd(4'h4, rv);
    chk("bit store", rv[9:0], 10'h1C1);
    run(mk(core_ops_pkg::OP_BLD, 5'h11, 5'h00, 3'h5, 16'h0000));
    rreg(5'h11, rv);
    chk("bit load", rv, 32'h0000_0020);
    bus_rd(4'h4, rv);
    chk("bit load flags", rv[9:0], 10'h1C1);
    $display("test transfer bit done");
    // Both branches, flag on and off, backward offset
    for (int b = 0; b < 4; b++) begin
      bus_wr(4'h4, {24'h0, b[0], 7'h00});
      bus_wr(4'h8, 32'h0000_0010);
      run(mk(b[1] ? core_ops_pkg::OP_BR_IOFF : core_ops_pkg::OP_BR_ION,
        5'h00, 5'h00, 3'h0, 16'h007D));
      bus_rd(4'h8, rv);
      chk("branch pc", rv[15:0],
        (b[0] ^ b[1]) ? 16'h000E : 16'h0011);
      bus_rd(4'h4, rv);
      chk("branch cycles", rv[9:0], {(b[0] ^ b[1]) ? 2'h2 : 2'h1, b[0], 7'h00});
    end
    $display("test branches done");
    // I/O bit set then clear on location 5
    mem_u.mem[16'h0025] = 8'h5A;
    bus_wr(4'h4, 32'h0000_0033);
    run(mk(core_ops_pkg::OP_IO_SET, 5'h00, 5'h00, 3'h0, 16'h0005));
    chk("io set", {24'h0, mem_u.mem[16'h0025]}, 32'h0000_005B);
    run(mk(core_ops_pkg::OP_IO_CLR, 5'h00, 5'h00, 3'h4, 16'h0005));
    chk("io clear", {24'h0, mem_u.mem[16'h0025]}, 32'h0000_004B);
    bus_rd(4'h4, rv);
    chk("io flags", rv[9:0], 10'h233);
    $display("test io bits done");
    // Pointers X=0x0200, Y=0x0300, Z=0x0400 then three of the four indirect forms
    for (int i = 0; i < 6; i++) begin
      direct_load(5'd26 + i[4:0], 16'h0180, i[0] ? {5'h00, 3'(i / 2 + 2)} : 8'h00);
    end
    ld_case(core_ops_pkg::OP_LD_INC, 5'h00, 16'h0000, 16'h0200, 8'h11, 5'd26, 16'h0201);
    ld_case(core_ops_pkg::OP_LD_DEC, 5'h01, 16'h0000, 16'h02FF, 8'h22, 5'd28, 16'h02FF);
    ld_case(core_ops_pkg::OP_LD_DISP, 5'h02, 16'h0005, 16'h0405, 8'h33, 5'd30, 16'h0400);
    $display("test indirect loads done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
